// [tcc_timer_core.sv]
// Timer counter core: status/control, clock select and the counter.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer_core (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extClkPin,
   input wire logic fixedClkTick,
   input wire logic pllActive,
   input wire logic debugActive,
   input wire logic [15:0] modulo,
   output logic [15:0] count,
   output logic countDown,
   output logic centerAlign,
   output logic counterTick,
   output logic overflowIrq
);
   // -----------------------------------------------------------------
   // Register decode
   // -----------------------------------------------------------------
   function automatic tcc_pkg::tcc_sel_t regSel(
      input logic [tcc_pkg::ADDR_W-1:0] a
   );
      tcc_pkg::tcc_sel_t s;
      s = tcc_pkg::SEL_NONE;
      if (a == tcc_pkg::ADDR_STATUS_CONTROL) begin
         s = tcc_pkg::SEL_STATUS;
      end else if (a == tcc_pkg::ADDR_COUNTER_HIGH) begin
         s = tcc_pkg::SEL_HIGH;
      end else if (a == tcc_pkg::ADDR_COUNTER_LOW) begin
         s = tcc_pkg::SEL_LOW;
      end
      return s;
   endfunction

   logic setupPhase;
   logic accessPhase;
   logic rdSc;
   logic wrSc;
   logic wrCnt;
   logic ovfFlag;
   logic irqEn;
   logic clearArmed;
   tcc_pkg::tcc_clksrc_t clkSrc;
   logic [2:0] presc;
   logic [7:0] statusByte;
   logic extSync1;
   logic extSync2;
   logic extSync3;
   logic extLevel;
   logic extRise;
   logic srcTick;
   logic presTickIn;
   logic [15:0] modTop;
   logic atTop;
   logic ovfEvent;
   logic [15:0] next_count;
   logic next_countDown;

   tcc_rdbuf_if rbus ();

   // Reads act at the setup edge, where their data is captured.
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign rdSc = setupPhase && !pwrite &&
                 regSel(paddr) == tcc_pkg::SEL_STATUS;
   assign wrSc = accessPhase && pwrite &&
                 regSel(paddr) == tcc_pkg::SEL_STATUS;
   assign wrCnt = accessPhase && pwrite &&
                  (regSel(paddr) == tcc_pkg::SEL_HIGH ||
                   regSel(paddr) == tcc_pkg::SEL_LOW);
   assign pready = 1'b1;

   assign statusByte = {ovfFlag, irqEn, centerAlign, clkSrc, presc};

   // -----------------------------------------------------------------
   // Bus read data
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prdata <= tcc_pkg::DATA_ZERO;
         pslverr <= 1'b0;
      end else if (clkEn && setupPhase) begin
         pslverr <= regSel(paddr) == tcc_pkg::SEL_NONE;
         unique case (regSel(paddr))
            tcc_pkg::SEL_STATUS: prdata <= {tcc_pkg::PAD_ZERO, statusByte};
            tcc_pkg::SEL_HIGH: prdata <= {tcc_pkg::PAD_ZERO, rbus.highByte};
            tcc_pkg::SEL_LOW: prdata <= {tcc_pkg::PAD_ZERO, rbus.lowByte};
            tcc_pkg::SEL_NONE: prdata <= tcc_pkg::DATA_ZERO;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Control fields
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irqEn <= 1'b0; // [R5]
         centerAlign <= 1'b0; // [R6]
         clkSrc <= tcc_pkg::CLKSRC_NONE;
         presc <= tcc_pkg::PRESC_RESET;
      end else if (clkEn && wrSc) begin
         irqEn <= pwdata[tcc_pkg::IRQ_EN_BIT];
         centerAlign <= pwdata[tcc_pkg::CENTER_BIT];
         clkSrc <= tcc_pkg::tcc_clksrc_t'(
                      pwdata[tcc_pkg::CLKSRC_HI:tcc_pkg::CLKSRC_LO]);
         presc <= pwdata[tcc_pkg::PRESC_HI:tcc_pkg::PRESC_LO]; // [R12]
      end
   end

   // -----------------------------------------------------------------
   // Overflow flag and its clearing sequence
   // -----------------------------------------------------------------
   // A new overflow disarms the sequence, so software must read again
   // before its zero write can clear the flag.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         clearArmed <= 1'b0;
      end else if (clkEn) begin
         if (ovfEvent) begin
            clearArmed <= 1'b0; // [R3]
         end else if (wrSc) begin
            clearArmed <= 1'b0;
         end else if (rdSc && ovfFlag) begin
            clearArmed <= 1'b1; // [R2]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ovfFlag <= 1'b0; // [R4]
      end else if (clkEn) begin
         if (ovfEvent) begin
            ovfFlag <= 1'b1; // [R1] [R3]
         end else if (wrSc && clearArmed &&
                      !pwdata[tcc_pkg::OVF_BIT]) begin
            ovfFlag <= 1'b0; // [R2] [R4]
         end
      end
   end

   assign overflowIrq = ovfFlag && irqEn; // [R5]

   // -----------------------------------------------------------------
   // Clock source selection
   // -----------------------------------------------------------------
   // The external pin may run at up to a quarter of the bus clock; a
   // faster source would lose edges in this sampler.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         extSync1 <= 1'b0;
         extSync2 <= 1'b0;
         extSync3 <= 1'b0;
         extLevel <= 1'b0;
      end else if (clkEn) begin
         extSync1 <= extClkPin; // [R8] [R20]
         extSync2 <= extSync1;
         extSync3 <= extSync2;
         if (extSync2 == extSync3) begin
            extLevel <= extSync2;
         end
      end
   end

   assign extRise = (extSync2 == extSync3) && extSync2 && !extLevel;

   always_comb begin
      unique case (clkSrc)
         tcc_pkg::CLKSRC_NONE: srcTick = 1'b0; // [R7] [R21]
         tcc_pkg::CLKSRC_BUS: srcTick = 1'b1; // [R7]
         tcc_pkg::CLKSRC_FIXED: begin
            srcTick = pllActive ? fixedClkTick : 1'b1; // [R9]
         end
         tcc_pkg::CLKSRC_EXT: srcTick = extRise; // [R7] [R8]
      endcase
   end

   // Debug stops the source too, so the prescaler phase is kept.
   assign presTickIn = srcTick && !debugActive; // [R16]

   tcc_prescaler u_prescaler (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clkEn(clkEn),
      .tickIn(presTickIn), // [R11]
      .presc(presc),
      .tickOut(counterTick)
   );

   // -----------------------------------------------------------------
   // Counter
   // -----------------------------------------------------------------
   assign modTop = (modulo == tcc_pkg::COUNT_ZERO) ?
                   tcc_pkg::COUNT_FULL : modulo; // [R19]
   assign atTop = (count == modTop) || (count == tcc_pkg::COUNT_FULL);

   always_comb begin
      next_count = count;
      next_countDown = centerAlign ? countDown : 1'b0; // [R6]
      ovfEvent = 1'b0;
      if (counterTick) begin
         if (!centerAlign) begin
            next_countDown = 1'b0; // [R6]
            if (atTop) begin
               next_count = tcc_pkg::COUNT_ZERO; // [R19]
               ovfEvent = 1'b1; // [R1]
            end else begin
               next_count = count + tcc_pkg::COUNT_ONE; // [R21]
            end
         end else if (!countDown) begin
            if (atTop) begin
               next_countDown = 1'b1; // [R6]
               next_count = count - tcc_pkg::COUNT_ONE;
            end else begin
               next_count = count + tcc_pkg::COUNT_ONE;
            end
         end else begin
            if (count == tcc_pkg::COUNT_ZERO) begin
               next_countDown = 1'b0;
               next_count = tcc_pkg::COUNT_ONE;
            end else begin
               next_count = count - tcc_pkg::COUNT_ONE;
               ovfEvent = (count == tcc_pkg::COUNT_ONE); // [R1]
            end
         end
      end
      if (wrCnt) begin
         ovfEvent = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         count <= tcc_pkg::COUNT_ZERO; // [R15]
         countDown <= 1'b0;
      end else if (clkEn) begin
         if (wrCnt) begin
            count <= tcc_pkg::COUNT_ZERO; // [R15]
            countDown <= 1'b0;
         end else begin
            count <= next_count;
            countDown <= next_countDown;
         end
      end
   end

   // -----------------------------------------------------------------
   // Read buffer
   // -----------------------------------------------------------------
   assign rbus.rdHigh = setupPhase && !pwrite &&
                        regSel(paddr) == tcc_pkg::SEL_HIGH;
   assign rbus.rdLow = setupPhase && !pwrite &&
                       regSel(paddr) == tcc_pkg::SEL_LOW;
   assign rbus.restart = wrSc || wrCnt; // [R14] [R15] [R18]
   assign rbus.freeze = debugActive; // [R17]
   assign rbus.liveCount = count; // [R16]

   tcc_rdbuf u_rdbuf (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clkEn(clkEn),
      .rb(rbus.buffer)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_ovf_set;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && ovfEvent |=> ovfFlag && count == tcc_pkg::COUNT_ZERO;
   endproperty
   a_ovf_set: assert property (p_ovf_set) // [R1]
      else $error("Overflow did not set the flag at zero.");

   property p_clear_needs_read;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && ovfFlag && !clearArmed |=> ovfFlag;
   endproperty
   a_clear_needs_read: assert property (p_clear_needs_read) // [R2]
      else $error("Flag cleared without a prior status read.");

   property p_clear_done;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && wrSc && clearArmed && !pwdata[tcc_pkg::OVF_BIT] &&
      !ovfEvent |=> !ovfFlag;
   endproperty
   a_clear_done: assert property (p_clear_done) // [R2]
      else $error("Armed zero write did not clear the flag.");

   property p_race;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && ovfEvent && wrSc |=> ovfFlag && !clearArmed;
   endproperty
   a_race: assert property (p_race) // [R3]
      else $error("Overflow lost during the clearing sequence.");

   property p_one_write;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && wrSc && pwdata[tcc_pkg::OVF_BIT] |=> $stable(ovfFlag);
   endproperty
   a_one_write: assert property (p_one_write) // [R4]
      else $error("Writing one changed the flag.");

   property p_irq;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && wrSc && pwdata[tcc_pkg::IRQ_EN_BIT] &&
      pwdata[tcc_pkg::OVF_BIT] && ovfFlag |=> overflowIrq;
   endproperty
   a_irq: assert property (p_irq) // [R5]
      else $error("Enabled overflow gave no interrupt.");

   property p_up_only;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && !centerAlign |=> !countDown;
   endproperty
   a_up_only: assert property (p_up_only) // [R6]
      else $error("Counter counted down outside center mode.");

   property p_hold_off;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && clkSrc == tcc_pkg::CLKSRC_NONE && !wrCnt |=> $stable(count);
   endproperty
   a_hold_off: assert property (p_hold_off) // [R21]
      else $error("Counter moved with no clock selected.");

   property p_cnt_clear;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && wrCnt |=> count == tcc_pkg::COUNT_ZERO;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) // [R15]
      else $error("Counter write did not zero the counter.");

   property p_debug;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && debugActive && !wrCnt |=> $stable(count);
   endproperty
   a_debug: assert property (p_debug) // [R16]
      else $error("Counter advanced during debug.");
endmodule

`default_nettype wire

// [tcc_pkg.sv]
// Constants and types shared by the timer counter core.
//
// Summary of operation
// [R1] Overflow flag sets when counter returns to zero.
// [R2] Flag clears by status read, then zero write.
// [R3] Overflow during clear sequence restarts the sequence.
// [R4] Writing one leaves flag; reset clears it.
// [R5] Interrupt requested while flag and enable set.
// [R6] Center select chooses up/down counting mode.
// [R7] Source field: none, bus, fixed, external.
// [R8] External source synchronised to bus clock.
// [R9] Fixed clock equals bus clock without PLL.
// [R10] Prescaler divides by two to the field.
// [R11] Prescaler follows source synchronisation and selection.
// [R12] New prescale value acts next cycle.
// [R13] Reading either byte latches both coherently.
// [R14] Reset or status write restarts read buffering.
// [R15] Reset or counter write zeroes the counter.
// [R16] Debug mode freezes counter; reads see frozen value.
// [R17] Debug mode freezes read buffer latches.
// [R18] Writes in debug still restart read buffering.
// [R19] Wrap after modulo; modulo zero free-runs.
// [R20] External clock at most quarter bus clock.
// [R21] One step per prescaler tick; hold when off.
`default_nettype none

package tcc_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h04;
   localparam logic [7:0] ADDR_COUNTER_LOW = 8'h08;

   typedef enum logic [1:0] {
      SEL_STATUS = 2'h0,
      SEL_HIGH = 2'h1,
      SEL_LOW = 2'h2,
      SEL_NONE = 2'h3
   } tcc_sel_t;

   // -----------------------------------------------------------------
   // Status and control fields
   // -----------------------------------------------------------------
   localparam int unsigned OVF_BIT = 7;
   localparam int unsigned IRQ_EN_BIT = 6;
   localparam int unsigned CENTER_BIT = 5;
   localparam int unsigned CLKSRC_HI = 4;
   localparam int unsigned CLKSRC_LO = 3;
   localparam int unsigned PRESC_HI = 2;
   localparam int unsigned PRESC_LO = 0;

   typedef enum logic [1:0] {
      CLKSRC_NONE = 2'h0,
      CLKSRC_BUS = 2'h1,
      CLKSRC_FIXED = 2'h2,
      CLKSRC_EXT = 2'h3
   } tcc_clksrc_t;

   localparam logic [2:0] PRESC_RESET = 3'h0;
   localparam int unsigned DIV_W = 7;
   localparam logic [DIV_W-1:0] DIV_ALL_ONES = 7'h7f;
   localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;

   // -----------------------------------------------------------------
   // Counter values
   // -----------------------------------------------------------------
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [15:0] COUNT_FULL = 16'hffff;
   localparam logic [23:0] PAD_ZERO = 24'h000000;
   localparam logic [31:0] DATA_ZERO = 32'h00000000;

   typedef enum logic [1:0] {
      RB_IDLE,
      RB_HOLD_FOR_LOW,
      RB_HOLD_FOR_HIGH
   } tcc_rdbuf_state_t;

endpackage

`default_nettype wire

// [tcc_rdbuf_if.sv]
// Signals between the core and its counter read buffer.
`timescale 1ns/1ps
`default_nettype none

interface tcc_rdbuf_if;
   logic rdHigh;
   logic rdLow;
   logic restart;
   logic freeze;
   logic [15:0] liveCount;
   logic [7:0] highByte;
   logic [7:0] lowByte;

   modport ctrl (
      output rdHigh, rdLow, restart, freeze, liveCount,
      input highByte, lowByte
   );
   modport buffer (
      input rdHigh, rdLow, restart, freeze, liveCount,
      output highByte, lowByte
   );
endinterface

`default_nettype wire

// [tcc_prescaler.sv]
// Power-of-two prescaler driven by the selected source tick.
`timescale 1ns/1ps
`default_nettype none

module tcc_prescaler (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic tickIn,
   input wire logic [2:0] presc,
   output logic tickOut
);
   logic [tcc_pkg::DIV_W-1:0] divCount;
   logic [tcc_pkg::DIV_W-1:0] mask;

   // The field is used live, so a new value acts on the next cycle.
   assign mask = ~(tcc_pkg::DIV_ALL_ONES << presc); // [R10] [R12]
   assign tickOut = tickIn && ((divCount & mask) == mask); // [R11]

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         divCount <= tcc_pkg::DIV_ZERO;
      end else if (clkEn && tickIn) begin
         divCount <= divCount + 1'b1;
      end
   end

   property p_div_one;
      @(posedge clk_sys) disable iff (!rstn)
      presc == tcc_pkg::PRESC_RESET |-> tickOut == tickIn;
   endproperty
   a_div_one: assert property (p_div_one) // [R10]
      else $error("Divide by one does not pass every tick.");

   property p_only_on_source;
      @(posedge clk_sys) disable iff (!rstn)
      tickOut |-> tickIn;
   endproperty
   a_only_on_source: assert property (p_only_on_source) // [R11]
      else $error("Prescaler ticked without a source tick.");
endmodule

`default_nettype wire

// [tcc_rdbuf.sv]
// Coherent two-byte read buffer for the counter.
`timescale 1ns/1ps
`default_nettype none

module tcc_rdbuf (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clkEn,
   tcc_rdbuf_if.buffer rb
);
   tcc_pkg::tcc_rdbuf_state_t state;
   logic [15:0] held;

   assign rb.highByte = (state == tcc_pkg::RB_IDLE) ?
                        rb.liveCount[15:8] : held[15:8]; // [R13]
   assign rb.lowByte = (state == tcc_pkg::RB_IDLE) ?
                       rb.liveCount[7:0] : held[7:0];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= tcc_pkg::RB_IDLE; // [R14]
         held <= tcc_pkg::COUNT_ZERO;
      end else if (clkEn) begin
         if (rb.restart) begin
            state <= tcc_pkg::RB_IDLE; // [R14] [R18]
         end else if (!rb.freeze) begin // [R17]
            unique case (state)
               tcc_pkg::RB_IDLE: begin
                  if (rb.rdHigh) begin
                     state <= tcc_pkg::RB_HOLD_FOR_LOW; // [R13]
                     held <= rb.liveCount;
                  end else if (rb.rdLow) begin
                     state <= tcc_pkg::RB_HOLD_FOR_HIGH; // [R13]
                     held <= rb.liveCount;
                  end
               end
               tcc_pkg::RB_HOLD_FOR_LOW: begin
                  if (rb.rdLow) begin
                     state <= tcc_pkg::RB_IDLE;
                  end
               end
               tcc_pkg::RB_HOLD_FOR_HIGH: begin
                  if (rb.rdHigh) begin
                     state <= tcc_pkg::RB_IDLE;
                  end
               end
               default: begin
                  state <= tcc_pkg::RB_IDLE;
               end
            endcase
         end
      end
   end

   property p_frozen;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && rb.freeze && !rb.restart |=> $stable(state) && $stable(held);
   endproperty
   a_frozen: assert property (p_frozen) // [R17]
      else $error("Read buffer moved during debug.");

   property p_restart;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && rb.restart |=> state == tcc_pkg::RB_IDLE;
   endproperty
   a_restart: assert property (p_restart) // [R14]
      else $error("Read buffer did not restart.");

   property p_latch_high;
      @(posedge clk_sys) disable iff (!rstn)
      clkEn && !rb.freeze && !rb.restart && rb.rdHigh &&
      state == tcc_pkg::RB_IDLE
      |=> state == tcc_pkg::RB_HOLD_FOR_LOW && held == $past(rb.liveCount);
   endproperty
   a_latch_high: assert property (p_latch_high) // [R13]
      else $error("High byte read did not latch the counter.");
endmodule

`default_nettype wire

// [tb_tcc_timer_core.sv]
// Self-checking testbench for the timer counter core.
`timescale 1ns/1ps
`default_nettype none

module tb_tcc_timer_core;
   logic clk_sys, rstn, clkEn, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, extClkPin, fixedClkTick;
   logic pllActive, debugActive, seenDown;
   logic [15:0] modulo, count, v, mx;
   logic countDown, centerAlign, counterTick, overflowIrq;
   int badCount, numChecks;
   localparam logic [7:0] SC = tcc_pkg::ADDR_STATUS_CONTROL;
   localparam logic [7:0] CH = tcc_pkg::ADDR_COUNTER_HIGH;
   localparam logic [7:0] CL = tcc_pkg::ADDR_COUNTER_LOW;

   tcc_timer_core tcc_timer_core_i (
      .clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extClkPin(extClkPin),
      .fixedClkTick(fixedClkTick), .pllActive(pllActive),
      .debugActive(debugActive), .modulo(modulo), .count(count),
      .countDown(countDown), .centerAlign(centerAlign),
      .counterTick(counterTick), .overflowIrq(overflowIrq)
   );

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // The core ties pready high and inserts no wait states; the access phase is still held
   // until pready is seen, and the bound keeps a stuck bus from hanging.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         badCount++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(nm, e, rd);
   endtask

   task automatic rdcnt();
      apb(1'b0, CH, 32'h00000000);
      v[15:8] = rd[7:0];
      apb(1'b0, CL, 32'h00000000);
      v[7:0] = rd[7:0];
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         fixedClkTick <= 1'b1;
         @(posedge clk_sys);
         fixedClkTick <= 1'b0;
      end
      cyc(3);
   endtask

   // -----------------------------------------------------------------
   // Stimulus
   // -----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      {rstn, psel, penable, pwrite, extClkPin, fixedClkTick} = 6'h00;
      {debugActive, seenDown} = 2'h0;
      {clkEn, pllActive} = 2'h3;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      modulo = 16'h0000;
      badCount = 0;
      numChecks = 0;
      cyc(6);
      rstn <= 1'b1;
      rdk("statusRst", SC, 32'h00000000);
      chk("countRst", 32'h00000000, {16'h0000, count});
      rdk("unmapped", 8'h0c, 32'h00000000);
      chk("slverr", 32'h00000001, {31'h0, err});
      $display("test reset done");
      modulo <= 16'h0005;
      wr(SC, 32'h00000048);
      cyc(30);
      wr(SC, 32'h00000040);
      rdk("ovfSet", SC, 32'h000000c0);
      chk("irqOn", 32'h00000001, {31'h0, overflowIrq});
      wr(SC, 32'h000000c0);
      rdk("writeOne", SC, 32'h000000c0);
      wr(SC, 32'h00000080);
      rdk("irqOffFlag", SC, 32'h00000080);
      chk("irqOff", 32'h00000000, {31'h0, overflowIrq});
      wr(SC, 32'h00000080);
      wr(SC, 32'h00000000);
      rdk("disarmed", SC, 32'h00000080);
      wr(SC, 32'h00000000);
      rdk("cleared", SC, 32'h00000000);
      modulo <= 16'h0001;
      wr(SC, 32'h00000010);
      wr(CL, 32'h00000000);
      tick(2);
      rdk("ovfFixed", SC, 32'h00000090);
      tick(2);
      wr(SC, 32'h00000010);
      rdk("rearm", SC, 32'h00000090);
      wr(SC, 32'h00000010);
      rdk("clear2", SC, 32'h00000010);
      $display("test flag done");
      modulo <= 16'h0000;
      for (int p = 0; p < 8; p++) begin
         wr(SC, 32'h00000010 | p);
         wr(CL, 32'h00000000);
         tick(3 << p);
         rdcnt();
         chk("presc", 32'h00000003, {16'h0000, v});
      end
      wr(SC, 32'h00000000);
      tick(5);
      rdcnt();
      chk("noClock", 32'h00000003, {16'h0000, v});
      wr(SC, 32'h00000018);
      wr(CL, 32'h00000000);
      repeat (4) begin
         cyc(4);
         extClkPin <= 1'b1;
         cyc(4);
         extClkPin <= 1'b0;
      end
      cyc(6);
      rdcnt();
      chk("extClk", 32'h00000004, {16'h0000, v});
      $display("test clock done");
      wr(SC, 32'h00000010);
      wr(CH, 32'h000000a5);
      tick(257);
      rdk("lowFirst", CL, 32'h00000001);
      tick(256);
      rdk("highSnap", CH, 32'h00000001);
      rdk("highNew", CH, 32'h00000002);
      tick(1);
      rdk("lowSnap", CL, 32'h00000001);
      rdk("lowArm", CL, 32'h00000002);
      tick(256);
      wr(SC, 32'h00000010);
      rdk("restart", CH, 32'h00000003);
      apb(1'b0, CL, 32'h00000000);
      wr(CL, 32'h0000005a);
      cyc(1);
      chk("cntWrite", 32'h00000000, {16'h0000, count});
      tick(5);
      rdk("dbgArm", CL, 32'h00000005);
      tick(2);
      debugActive <= 1'b1;
      tick(3);
      chk("dbgFreeze", 32'h00000007, {16'h0000, count});
      rdk("dbgHigh", CH, 32'h00000000);
      rdk("dbgLow", CL, 32'h00000005);
      debugActive <= 1'b0;
      rdk("dbgDone", CH, 32'h00000000);
      rdcnt();
      chk("dbgLive", 32'h00000007, {16'h0000, v});
      $display("test buffer done");
      pllActive <= 1'b0;
      wr(CL, 32'h00000000);
      cyc(20);
      rdcnt();
      chk("noPll", 32'h00000001, {31'h0, v > 16'h000a});
      pllActive <= 1'b1;
      modulo <= 16'h0003;
      mx = 16'h0000;
      wr(CL, 32'h00000000);
      wr(SC, 32'h00000028);
      repeat (40) begin
         @(negedge clk_sys);
         seenDown = seenDown | (countDown === 1'b1);
         mx = (count > mx) ? count : mx;
      end
      chk("tickBus", 32'h00000001, {31'h0, counterTick});
      chk("center", 32'h00000001, {31'h0, centerAlign});
      chk("centerTop", 32'h00000003, {16'h0000, mx});
      chk("downSeen", 32'h00000001, {31'h0, seenDown});
      rdk("centerOvf", SC, 32'h000000a8);
      $display("test center done");
      results();
   end
endmodule

`default_nettype wire
